// ==== core/aptc_pkg.sv ====
// Purpose: shared constants and types of the light/proximity timing block
// Assumes: 25 MHz system clock; the oscillator is modelled as a tick enable
// Notes: register offsets are byte addresses of the sensor register map
package aptc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] APTC_ADDR_ENABLE = 8'h80;
    localparam logic [7:0] APTC_ADDR_STEPS = 8'h81;
    localparam logic [7:0] APTC_ADDR_PERIOD = 8'h82;
    localparam logic [7:0] APTC_RST_ENABLE = 8'h00;
    localparam logic [7:0] APTC_RST_STEPS = 8'h00;
    localparam logic [7:0] APTC_RST_PERIOD = 8'h1f;
    localparam int APTC_BIT_PON = 0;
    localparam int APTC_BIT_ALS_EN = 1;
    localparam int APTC_BIT_PROX_EN = 2;

    // ==========================================================
    // timing
    localparam int APTC_CLK_HZ = 25_000_000;
    localparam int APTC_OSC_HZ = 8_000_000;
    localparam int APTC_OSC_DIV = 11;
    localparam int APTC_STEP_ICLK = 2048;
    localparam int APTC_PROX_UNIT_US = 88;
    localparam int APTC_PROX_UNIT_ICLK =
        (APTC_PROX_UNIT_US * (APTC_OSC_HZ / 1_000_000)) / APTC_OSC_DIV;
    localparam logic [4:0] APTC_ACC_ADD = 5'(APTC_OSC_HZ / 1_000_000);
    localparam logic [4:0] APTC_ACC_MOD = 5'(APTC_CLK_HZ / 1_000_000);
    localparam logic [3:0] APTC_DIV_LAST = 4'(APTC_OSC_DIV - 1);
    localparam logic [10:0] APTC_STEP_LAST = 11'(APTC_STEP_ICLK - 1);
    localparam logic [5:0] APTC_PROX_LAST = 6'(APTC_PROX_UNIT_ICLK - 1);

    // ==========================================================
    // light count limits
    localparam logic [15:0] APTC_LIGHT_FULL = 16'hffff;
    localparam int APTC_LIGHT_SHIFT = 10;

    // ==========================================================
    // types
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aptc_reg_req_t;

    typedef enum logic [0:0] {
        APTC_IDLE = 1'b0,
        APTC_RUN = 1'b1
    } aptc_state_t;

endpackage

// ==== core/aptc_step_timer.sv ====
// Purpose: down counter of steps, each step a fixed number of slow ticks
// Assumes: tick_in is a one-cycle enable
// Notes: reloads from load_in at each start, so a new value waits its turn
module aptc_step_timer import aptc_pkg::*; #(
    parameter int SUB_W = 11,
    parameter logic [SUB_W-1:0] SUB_LAST = '1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic tick_in,
    input wire logic [7:0] load_in,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] steps_left_out
);

    aptc_state_t state_r;
    logic [SUB_W-1:0] sub_r;

    // ==========================================================
    // step sequencing
    always_ff @(posedge clk_in) begin
        if (rst_in || !run_in) begin
            state_r <= APTC_IDLE;
            sub_r <= '0;
            steps_left_out <= 8'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (tick_in) begin
                case (state_r)
                    APTC_IDLE: begin
                        // R10: value taken at start
                        steps_left_out <= load_in;
                        sub_r <= '0;
                        state_r <= APTC_RUN;
                    end
                    APTC_RUN: begin
                        if (sub_r == SUB_LAST) begin
                            sub_r <= '0;
                            // R2: terminal count zero
                            if (steps_left_out == 8'h00) begin
                                done_out <= 1'b1;
                                // R10: reload for next cycle
                                steps_left_out <= load_in;
                            end else begin
                                steps_left_out <= steps_left_out - 8'h01;
                            end
                        end else begin
                            sub_r <= sub_r + 1'b1;
                        end
                    end
                    default: state_r <= APTC_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !run_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state_r == APTC_RUN);
        end
    end

endmodule

// ==== core/aptc_timing.sv ====
// Purpose: integration and proximity sample timing of an optical sensor
// Assumes: register port is synchronous, one access per strobe cycle
// Notes: oscillator rate is made from clk_in by a fractional accumulator
//
// Notes on behaviour
// R1: integration lasts value plus one steps
// R2: down counter ends at terminal zero
// R3: max count 1024*(value+1)-1, saturate 65535
// R4: host needs 64 steps for full scale
// R5: integration clock is oscillator divided by 11
// R6: one step is 2048 integration clocks
// R7: proximity sample is value plus one 88us
// R8: oscillator and timers run only with power-on
// R9: light integration needs enable and power-on
// R10: new values apply from next cycle start
module aptc_timing import aptc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire aptc_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic osc_run_out,
    output logic als_busy_out,
    output logic als_done_out,
    output logic [15:0] als_max_count_out,
    output logic prox_busy_out,
    output logic prox_done_out
);

    logic [7:0] enable_r;
    logic [7:0] steps_r;
    logic [7:0] period_r;
    logic [4:0] acc_r;
    logic [5:0] acc_sum;
    logic osc_tick_r;
    logic [3:0] div_r;
    logic iclk_tick_r;
    logic pon;
    logic als_run;
    logic prox_run;
    logic [7:0] als_left;
    logic [7:0] prox_left;

    assign pon = enable_r[APTC_BIT_PON];
    // R9: both bits needed
    assign als_run = pon && enable_r[APTC_BIT_ALS_EN];
    assign prox_run = pon && enable_r[APTC_BIT_PROX_EN];
    // one bit wider than the accumulator so the sum cannot wrap
    assign acc_sum = {1'b0, acc_r} + {1'b0, APTC_ACC_ADD};

    // ==========================================================
    // register writes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_r <= APTC_RST_ENABLE;
            steps_r <= APTC_RST_STEPS;
            period_r <= APTC_RST_PERIOD;
        end else if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                APTC_ADDR_ENABLE: enable_r <= reg_req_in.wdata;
                APTC_ADDR_STEPS: steps_r <= reg_req_in.wdata;
                APTC_ADDR_PERIOD: period_r <= reg_req_in.wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // register reads
    // unmapped offsets read zero; data is held until the next read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                APTC_ADDR_ENABLE: reg_rdata_out <= enable_r;
                APTC_ADDR_STEPS: reg_rdata_out <= steps_r;
                APTC_ADDR_PERIOD: reg_rdata_out <= period_r;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // oscillator model
    // 8 ticks per 25 clocks; jitter of one clk_in period per tick is
    // the price of a single clock domain
    always_ff @(posedge clk_in) begin
        // R8: stopped without power-on
        if (rst_in || !pon) begin
            acc_r <= 5'h00;
            osc_tick_r <= 1'b0;
        end else if (acc_sum >= {1'b0, APTC_ACC_MOD}) begin
            acc_r <= 5'(acc_sum - {1'b0, APTC_ACC_MOD});
            osc_tick_r <= 1'b1;
        end else begin
            acc_r <= acc_sum[4:0];
            osc_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            osc_run_out <= 1'b0;
        end else begin
            osc_run_out <= pon;
        end
    end

    // ==========================================================
    // integration clock divider
    always_ff @(posedge clk_in) begin
        if (rst_in || !pon) begin
            div_r <= 4'h0;
            iclk_tick_r <= 1'b0;
        end else begin
            iclk_tick_r <= 1'b0;
            if (osc_tick_r) begin
                // R5: divide by eleven
                if (div_r == APTC_DIV_LAST) begin
                    div_r <= 4'h0;
                    iclk_tick_r <= 1'b1;
                end else begin
                    div_r <= div_r + 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // light integration timer
    // R1: steps value plus one
    // R6: 2048 clocks per step
    aptc_step_timer #(
        .SUB_W(11),
        .SUB_LAST(APTC_STEP_LAST)
    ) u_als_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(als_run),
        .tick_in(iclk_tick_r),
        .load_in(steps_r),
        .busy_out(als_busy_out),
        .done_out(als_done_out),
        .steps_left_out(als_left)
    );

    // ==========================================================
    // light full scale
    // only reflects the value loaded at a cycle start, so it tracks what
    // the running integration can actually reach
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            als_max_count_out <= 16'(({8'h00, APTC_RST_STEPS} + 16'h0001) << APTC_LIGHT_SHIFT)
                - 16'h0001;
        end else if (als_run && iclk_tick_r && !als_busy_out) begin
            // R3: grows 1024 per step
            if (steps_r[7:6] != 2'b00) begin
                als_max_count_out <= APTC_LIGHT_FULL;
            end else begin
                als_max_count_out <= {steps_r[5:0], 10'h3ff};
            end
        end else if (als_done_out) begin
            // R10: back-to-back cycles take the reloaded count
            if (als_left[7:6] != 2'b00) begin
                als_max_count_out <= APTC_LIGHT_FULL;
            end else begin
                als_max_count_out <= {als_left[5:0], 10'h3ff};
            end
        end
    end

    // ==========================================================
    // proximity sample timer
    // R7: 88us units
    aptc_step_timer #(
        .SUB_W(6),
        .SUB_LAST(APTC_PROX_LAST)
    ) u_prox_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(prox_run),
        .tick_in(iclk_tick_r),
        .load_in(period_r),
        .busy_out(prox_busy_out),
        .done_out(prox_done_out),
        .steps_left_out(prox_left)
    );

endmodule

// ==== tb/aptc_timing_props.sv ====
// Purpose: port checks of aptc_timing
// Assumes: one clock, synchronous reset
// Notes: register port is judged by the bench
module aptc_timing_props import aptc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire aptc_reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic osc_run_out,
    input wire logic als_busy_out,
    input wire logic als_done_out,
    input wire logic [15:0] als_max_count_out,
    input wire logic prox_busy_out,
    input wire logic prox_done_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // ====
    // sequences
    sequence als_quiet8;
        !als_done_out [*8];
    endsequence
    sequence prox_quiet8;
        !prox_done_out [*8];
    endsequence
    AST_ALS_PULSE: assert property (als_done_out |=> als_quiet8)
        else $error("light done too close");
    AST_ALS_FIRST: assert property ($rose(als_busy_out) |-> als_quiet8)
        else $error("light step too short");
    AST_ALS_END: assert property (als_done_out |-> $past(als_busy_out))
        else $error("light done while idle");
    AST_PROX_PULSE: assert property (prox_done_out |=> prox_quiet8)
        else $error("prox done too close");
    AST_OFF_STOP: assert property ($fell(osc_run_out) |-> ##[0:2] !(als_busy_out || prox_busy_out))
        else $error("timers run after power off");
    AST_OFF_IDLE: assert property (!osc_run_out [*3] |-> !(als_busy_out || prox_busy_out))
        else $error("timer busy without power");
    AST_MAX_LOW: assert property (als_max_count_out[9:0] == 10'h3ff)
        else $error("max count not a step multiple");
    AST_MAX_HOLD: assert property (als_busy_out && $past(als_busy_out) && $past(als_busy_out, 2)
        && !$past(als_done_out) && !$past(als_done_out, 2) |-> $stable(als_max_count_out))
        else $error("max count moved mid cycle");
endmodule
bind aptc_timing aptc_timing_props aptc_timing_props_i (
    .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .osc_run_out(osc_run_out),
    .als_busy_out(als_busy_out), .als_done_out(als_done_out),
    .als_max_count_out(als_max_count_out), .prox_busy_out(prox_busy_out),
    .prox_done_out(prox_done_out));

// ==== tb/testbench.sv ====
// Purpose: register and timing tests of aptc_timing
// Assumes: 25 MHz clock, inputs change on the falling edge
// Notes: a light step is about 70400 clocks, so one full cycle runs
module testbench import aptc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in;
    logic rst_in;
    aptc_reg_req_t req;
    logic [7:0] rdata;
    logic osc, abusy, adone, pbusy, pdone;
    logic [15:0] maxc;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int t0;
    int t1;
    aptc_timing aptc_timing_i (.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .osc_run_out(osc), .als_busy_out(abusy),
        .als_done_out(adone), .als_max_count_out(maxc), .prox_busy_out(pbusy),
        .prox_done_out(pdone));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    // ====
    // tasks
    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_in);
        req = '0;
        @(negedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_in);
        req = '0;
        @(negedge clk_in);
        chk($sformatf("reg %h", a), 16'(e), 16'(rdata));
    endtask
    // bounded wait: sel 0 light busy, 1 light done, 2 prox done
    task automatic wait_hi(input int sel, input int lim);
        for (int n = 0; n <= lim; n++) begin
            @(negedge clk_in);
            if ((({pdone, adone, abusy} >> sel) & 3'h1) === 3'h1) return;
        end
        errors++;
        final_report();
    endtask
    // ====
    // sequence
    initial begin
        req = '0;
        rst_in = 1'b1;
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        rd(8'h80, 8'h00);
        rd(8'h81, 8'h00);
        rd(8'h82, 8'h1f);
        chk("max", 16'h03ff, maxc);
        wr(8'h81, 8'h05);
        wr(8'h82, 8'hff);
        wr(8'h83, 8'haa);
        rd(8'h81, 8'h05);
        rd(8'h82, 8'hff);
        rd(8'h83, 8'h00);
        wr(8'h80, 8'h06);
        repeat (300) @(negedge clk_in);
        chk("osc", 16'h0000, 16'(osc));
        chk("busy", 16'h0000, 16'(abusy | pbusy));
        wr(8'h80, 8'h01);
        repeat (300) @(negedge clk_in);
        chk("osc", 16'h0001, 16'(osc));
        chk("busy", 16'h0000, 16'(abusy | pbusy));
        wr(8'h81, 8'h00);
        wr(8'h82, 8'h00);
        wr(8'h80, 8'h07);
        wait_hi(0, 200);
        t0 = cyc;
        wait_hi(2, 3000);
        t1 = cyc;
        wait_hi(2, 3000);
        chk("prox len", 16'h0001, 16'(cyc - t1 >= 2160 && cyc - t1 <= 2240));
        wr(8'h81, 8'h40);
        chk("max", 16'h03ff, maxc);
        wait_hi(1, 72000);
        chk("light len", 16'h0001, 16'(cyc - t0 >= 70360 && cyc - t0 <= 70440));
        repeat (4) @(negedge clk_in);
        chk("max", 16'hffff, maxc);
        wr(8'h80, 8'h00);
        repeat (3) @(negedge clk_in);
        chk("osc", 16'h0000, 16'(osc));
        chk("busy", 16'h0000, 16'(abusy | pbusy));
        final_report();
    end
endmodule
